// ==== core/wcp_capture_port.v ====
// Waveform capture serial master: streams measurement words out each sampling cycle
//
// Behaviour
// - Port off after reset; runs only while general-config enable bit is one.
// - Enable bit ignored unless host link is in I2C mode.
// - Each 24-bit signed word is sign extended to 32 bits.
// - Port is master only: drives clock, select and data, receives nothing.
// - After reset data and select outputs are high.
// - Clock-rate bit: zero gives fast serial clock, one gives half rate.
// - A new data bit appears at every falling serial clock edge.
// - Size bit picks 32-bit or 8-bit packages; MSB first.
// - Gap bit set inserts seven idle clock cycles between packages.
// - With gap bit clear, size bit is ignored; bits stream continuously.
// - Set code 00 sends all sixteen words, samples first then powers.
// - Set code 01 sends the seven current and voltage samples.
// - Set code 10 sends the nine phase powers.
// - Set code 11 behaves exactly like 00.
// - Polarity zero: select high idle, low in packages, high in gaps.
// - Polarity one: select low idle, high in packages, low in gaps.
// - Writes to the two top config bits change nothing.
// - Transfer shorter than a sample period starts every sampling cycle.
// - Longer transfer runs only in first of each pair of sampling cycles.
`timescale 1ns/1ps
`include "wcp_regs.vh"
module wcp_capture_port #(
  parameter SAMPLE_CYCLES = `WCP_SAMPLE_PERIOD_NS / `WCP_CLK_PERIOD_NS,
  parameter DATA_W = 24
) (
  input wire clock,
  input wire rst_b,
  input wire host_link_i2c,
  input wire [`WCP_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  input wire sample_wr,
  input wire [3:0] sample_idx,
  input wire [DATA_W-1:0] sample_data,
  output reg sample_tick_q,
  output reg serial_clock_out_q,
  output reg serial_data_out_q,
  output reg select_out_q
);

  // ------------------------------------------------------------------
  // Timing constants
  // ------------------------------------------------------------------
  // Longest half period that fits, so the link never runs slow
  localparam integer HALF_FAST_I = `WCP_HALF_FAST_PS / `WCP_CLK_PERIOD_PS;
  localparam integer HALF_SLOW_I = `WCP_HALF_SLOW_PS / `WCP_CLK_PERIOD_PS;
  localparam [3:0] HALF_FAST = HALF_FAST_I[3:0];
  localparam [3:0] HALF_SLOW = HALF_SLOW_I[3:0];

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SHIFT = 2'd1;
  localparam [1:0] ST_GAP = 2'd2;

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function [3:0] first_idx;
    input [1:0] set;
    begin
      if (set == `WCP_SET_POWER) begin
        first_idx = `WCP_IDX_FIRST_POWER;
      end else begin
        first_idx = `WCP_IDX_FIRST;
      end
    end
  endfunction

  function [3:0] last_idx;
    input [1:0] set;
    begin
      if (set == `WCP_SET_WAVE) begin
        last_idx = `WCP_IDX_LAST_WAVE;
      end else begin
        last_idx = `WCP_IDX_LAST;
      end
    end
  endfunction

  function [31:0] sign_ext;
    input [DATA_W-1:0] v;
    begin
      sign_ext = {{(32-DATA_W){v[DATA_W-1]}}, v};
    end
  endfunction

  // ------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;
  reg i2c_meta_q;
  reg i2c_q;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      i2c_meta_q <= 1'b0;
      i2c_q <= 1'b0;
    end else begin
      i2c_meta_q <= host_link_i2c;
      i2c_q <= i2c_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  reg gen_en_q;
  reg [7:0] port_cfg_q;
  reg [1:0] state_q;
  reg skipped_q;
  wire run_en;
  wire busy;

  // Enable only honoured in I2C host mode
  assign run_en = gen_en_q & i2c_q;
  assign busy = (state_q != ST_IDLE);

  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      gen_en_q <= 1'b0;
      port_cfg_q <= `WCP_CFG_RST;
      reg_rdata_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `WCP_REG_GEN_CFG) begin
        gen_en_q <= reg_wdata[`WCP_GEN_EN_BIT];
      end
      if (reg_wr && reg_addr == `WCP_REG_PORT_CFG) begin
        port_cfg_q <= reg_wdata & `WCP_CFG_STORE_MASK;
      end
      if (reg_rd) begin
        case (reg_addr)
          `WCP_REG_GEN_CFG: begin
            reg_rdata_q <= {1'b0, gen_en_q, 6'h00};
          end
          `WCP_REG_PORT_CFG: begin
            reg_rdata_q <= port_cfg_q;
          end
          `WCP_REG_STATUS: begin
            reg_rdata_q <= {5'h00, skipped_q, i2c_q, busy};
          end
          default: begin
            reg_rdata_q <= 8'h00;
          end
        endcase
      end else begin
        reg_rdata_q <= 8'h00;
      end
    end
  end

  wire cfg_slow = port_cfg_q[`WCP_CFG_CLK_BIT];
  wire cfg_size8 = port_cfg_q[`WCP_CFG_SIZE_BIT];
  wire cfg_gap = port_cfg_q[`WCP_CFG_GAP_BIT];
  wire [1:0] cfg_set = port_cfg_q[`WCP_CFG_SET_HI:`WCP_CFG_SET_LO];
  wire cfg_pol = port_cfg_q[`WCP_CFG_POL_BIT];

  // ------------------------------------------------------------------
  // Sampling-cycle timer
  // ------------------------------------------------------------------
  reg [15:0] smp_cnt_q;

  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      smp_cnt_q <= 16'h0000;
      sample_tick_q <= 1'b0;
    end else begin
      if (smp_cnt_q == SAMPLE_CYCLES[15:0] - 16'h0001) begin
        smp_cnt_q <= 16'h0000;
        sample_tick_q <= 1'b1;
      end else begin
        smp_cnt_q <= smp_cnt_q + 16'h0001;
        sample_tick_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Sample memory
  // ------------------------------------------------------------------
  reg [3:0] word_q;
  wire [DATA_W-1:0] mem_rdata;

  wcp_sample_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(4)
  ) u_mem (
    .clock(clock),
    .wr_en(sample_wr),
    .wr_addr(sample_idx),
    .wr_data(sample_data),
    .rd_addr(word_q),
    .rd_data_q(mem_rdata)
  );

  // ------------------------------------------------------------------
  // Serial clock half-period divider
  // ------------------------------------------------------------------
  reg [3:0] half_cnt_q;
  wire [3:0] half_len = cfg_slow ? HALF_SLOW : HALF_FAST;
  wire half_tick = busy && (half_cnt_q == half_len - 4'h1);

  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      half_cnt_q <= 4'h0;
    end else if (!busy || half_tick) begin
      half_cnt_q <= 4'h0;
    end else begin
      half_cnt_q <= half_cnt_q + 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------------
  reg [4:0] bit_q;
  reg [3:0] gap_q;
  reg [31:0] shift_q;
  reg act_q;

  // Package boundary: byte end only when gaps are on
  wire pkg_end = (cfg_gap && cfg_size8) ? (bit_q[2:0] == `WCP_BYTE_LAST_BIT)
                                        : (bit_q == `WCP_WORD_LAST_BIT);
  wire word_end = (bit_q == `WCP_WORD_LAST_BIT);
  wire last_word = (word_q == last_idx(cfg_set));
  wire [31:0] word_ext = sign_ext(mem_rdata);

  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ST_IDLE;
      bit_q <= 5'h00;
      gap_q <= 4'h0;
      word_q <= 4'h0;
      shift_q <= 32'h0000_0000;
      act_q <= 1'b0;
      skipped_q <= 1'b0;
      serial_clock_out_q <= 1'b1;
      serial_data_out_q <= 1'b1;
    end else if (!run_en) begin
      state_q <= ST_IDLE;
      act_q <= 1'b0;
      serial_clock_out_q <= 1'b1;
      serial_data_out_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          serial_clock_out_q <= 1'b1;
          serial_data_out_q <= 1'b1;
          act_q <= 1'b0;
          if (sample_tick_q) begin
            state_q <= ST_SHIFT;
            word_q <= first_idx(cfg_set);
            bit_q <= 5'h00;
            act_q <= 1'b1;
            skipped_q <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (half_tick && serial_clock_out_q) begin
            serial_clock_out_q <= 1'b0;
            if (bit_q == 5'h00) begin
              serial_data_out_q <= word_ext[31];
              shift_q <= {word_ext[30:0], 1'b0};
            end else begin
              serial_data_out_q <= shift_q[31];
              shift_q <= {shift_q[30:0], 1'b0};
            end
          end else if (half_tick) begin
            // Rising edge: receiver takes the bit here
            serial_clock_out_q <= 1'b1;
            bit_q <= bit_q + 5'h01;
            if (word_end && last_word) begin
              // Data returns high in idle, never on the sampling edge
              state_q <= ST_IDLE;
              act_q <= 1'b0;
            end else begin
              if (word_end) begin
                word_q <= word_q + 4'h1;
              end
              if (pkg_end && cfg_gap) begin
                state_q <= ST_GAP;
                gap_q <= 4'h0;
                act_q <= 1'b0;
              end
            end
          end
        end
        ST_GAP: begin
          // Clock held high through the gap
          if (half_tick) begin
            if (gap_q == `WCP_GAP_HALVES - 4'h1) begin
              state_q <= ST_SHIFT;
              act_q <= 1'b1;
            end else begin
              gap_q <= gap_q + 4'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // A tick landing mid-transfer is dropped, halving the rate
      if (sample_tick_q && busy) begin
        skipped_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Select output
  // ------------------------------------------------------------------
  always @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      select_out_q <= 1'b1;
    end else begin
      select_out_q <= act_q ? cfg_pol : ~cfg_pol;
    end
  end

  // Only outputs exist on the link side; nothing is received

endmodule // wcp_capture_port

// ==== core/wcp_regs.vh ====
// Register map, field positions, reset values and timing figures of the capture port
`ifndef WCP_REGS_VH
`define WCP_REGS_VH

// Register indices on the plain register port
`define WCP_ADDR_W 4
`define WCP_REG_GEN_CFG 4'h0
`define WCP_REG_PORT_CFG 4'h1
`define WCP_REG_STATUS 4'h2

// General configuration fields
`define WCP_GEN_EN_BIT 6
`define WCP_GEN_RST 8'h00

// Port configuration fields
`define WCP_CFG_CLK_BIT 0
`define WCP_CFG_SIZE_BIT 1
`define WCP_CFG_GAP_BIT 2
`define WCP_CFG_SET_LO 3
`define WCP_CFG_SET_HI 4
`define WCP_CFG_POL_BIT 5
`define WCP_CFG_STORE_MASK 8'h3f
`define WCP_CFG_RST 8'h00

// Word-set codes
`define WCP_SET_ALL 2'b00
`define WCP_SET_WAVE 2'b01
`define WCP_SET_POWER 2'b10

// Word indices in the sample memory
`define WCP_IDX_FIRST 4'h0
`define WCP_IDX_LAST_WAVE 4'h6
`define WCP_IDX_FIRST_POWER 4'h7
`define WCP_IDX_LAST 4'hf

// Package geometry
`define WCP_WORD_LAST_BIT 5'h1f
`define WCP_BYTE_LAST_BIT 3'h7
`define WCP_GAP_HALVES 4'he

// Timing, in picoseconds and nanoseconds
`define WCP_CLK_PERIOD_PS 20000
`define WCP_HALF_FAST_PS 62500
`define WCP_HALF_SLOW_PS 125000
`define WCP_SAMPLE_PERIOD_NS 125000
`define WCP_CLK_PERIOD_NS 20

`endif

// ==== core/wcp_sample_mem.v ====
// Sixteen-word store of the latest measurement values, registered read
`timescale 1ns/1ps
module wcp_sample_mem #(
  parameter DATA_W = 24,
  parameter ADDR_W = 4
) (
  input wire clock,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [DATA_W-1:0] wr_data,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [DATA_W-1:0] rd_data_q
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule // wcp_sample_mem

// ==== bench/wcp_capture_port_sva.sv ====
// Concurrent checks on the capture port pins and sampling tick
`timescale 1ns/1ps
`include "wcp_regs.vh"
module wcp_capture_port_sva #(
  parameter SAMPLE_CYCLES = 6250,
  parameter DATA_W = 24
) (
  input wire clock,
  input wire rst_b,
  input wire host_link_i2c,
  input wire [`WCP_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  input wire sample_wr,
  input wire [3:0] sample_idx,
  input wire [DATA_W-1:0] sample_data,
  input wire sample_tick_q,
  input wire serial_clock_out_q,
  input wire serial_data_out_q,
  input wire select_out_q
);
  // ----
  // Shadow of the configuration
  // ----
  reg [7:0] cfg_q;
  reg en_q;
  reg seen_q;
  reg [15:0] tk_q;
  reg [15:0] lo_q;
  reg [2:0] dis_q;
  reg pol_q;
  // Select follows the config one cycle late: compare with the lagged polarity
  wire act = select_out_q == pol_q;
  wire sck = serial_clock_out_q;
  wire [3:0] hp = cfg_q[`WCP_CFG_CLK_BIT] ? 4'h6 : 4'h3;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= 8'h00;
      en_q <= 1'b0;
      seen_q <= 1'b0;
      tk_q <= 16'h0000;
      lo_q <= 16'h0000;
      dis_q <= 3'h0;
      pol_q <= 1'b0;
    end else begin
      pol_q <= cfg_q[`WCP_CFG_POL_BIT];
      if (reg_wr && reg_addr == `WCP_REG_PORT_CFG) cfg_q <= reg_wdata;
      if (reg_wr && reg_addr == `WCP_REG_GEN_CFG) en_q <= reg_wdata[`WCP_GEN_EN_BIT];
      seen_q <= seen_q | sample_tick_q;
      tk_q <= sample_tick_q ? 16'h0000 : tk_q + 16'h0001;
      // Saturate so a long idle never wraps into a short gap
      lo_q <= act ? 16'h0000 : lo_q + {15'h0000, lo_q != 16'hffff};
      // Writes restart the count: the idle level may follow a polarity change
      dis_q <= (reg_wr || (en_q && host_link_i2c)) ? 3'h0 : dis_q + {2'h0, dis_q != 3'h7};
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_rst_idle; $rose(rst_b) |-> select_out_q && serial_data_out_q && sck; endproperty
  property p_dis_idle; dis_q == 3'h7 |-> act == 1'b0 && sck && serial_data_out_q; endproperty
  property p_dat_rise; $rose(sck) |-> $stable(serial_data_out_q); endproperty
  property p_dat_low; !sck && $past(!sck) |-> $stable(serial_data_out_q); endproperty
  property p_half_f; $fell(sck) && !cfg_q[0] |-> !sck[*3] ##1 sck; endproperty
  property p_half_s; $fell(sck) && cfg_q[0] |-> !sck[*6] ##1 sck; endproperty
  property p_gap_clk; !act |-> sck; endproperty
  property p_gap_len; $rose(act) |-> lo_q + 1 >= 14 * hp; endproperty
  property p_tick; sample_tick_q && seen_q |-> tk_q == SAMPLE_CYCLES - 1; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins not high after reset");
  a_dis_idle: assert property (p_dis_idle) else $error("port active while off");
  a_dat_rise: assert property (p_dat_rise) else $error("data moved at rising clock");
  a_dat_low: assert property (p_dat_low) else $error("data moved while clock low");
  a_half_f: assert property (p_half_f) else $error("fast low phase wrong");
  a_half_s: assert property (p_half_s) else $error("slow low phase wrong");
  a_gap_clk: assert property (p_gap_clk) else $error("clock ran with select off");
  a_gap_len: assert property (p_gap_len) else $error("gap too short");
  a_tick: assert property (p_tick) else $error("sampling period wrong");
  c_start: cover property ($rose(act));
  c_gap: cover property ($rose(act) && lo_q < 16'h0200);
  c_tick: cover property (sample_tick_q && seen_q);
endmodule // wcp_capture_port_sva

bind wcp_capture_port wcp_capture_port_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .DATA_W(DATA_W)) u_sva (
  .clock(clock), .rst_b(rst_b), .host_link_i2c(host_link_i2c), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sample_wr(sample_wr), .sample_idx(sample_idx),
  .sample_data(sample_data), .sample_tick_q(sample_tick_q), .serial_clock_out_q(serial_clock_out_q),
  .serial_data_out_q(serial_data_out_q), .select_out_q(select_out_q));

// ==== bench/wcp_rx_model.sv ====
// Receiving slave on the capture link: collects words, counts packages
`timescale 1ns/1ps
module wcp_rx_model (
  input wire sck,
  input wire sd,
  input wire sel,
  input wire pol
);
  logic [31:0] sr = 32'h0000_0000;
  int bits = 0;
  int acts = 0;
  logic [31:0] q[$];
  // Listen only: the link has no return path
  always @(posedge sck) begin
    if (sel === pol) begin
      sr = {sr[30:0], sd};
      bits++;
      if (bits == 32) begin
        q.push_back(sr);
        bits = 0;
      end
    end
  end
  always @(sel) begin
    if (sel === pol) acts++;
  end
endmodule // wcp_rx_model

// ==== bench/waveform_capture_serial_master_bench.sv ====
// Random and corner tests of the waveform capture serial master
`timescale 1ns/1ps
`include "wcp_regs.vh"
module waveform_capture_serial_master_bench;
  localparam int SC = 2500;
  logic clock = 0;
  logic rst_b = 0;
  logic i2c = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic wr_s = 0;
  logic rd_s = 0;
  logic [7:0] rdat;
  logic s_wr = 0;
  logic [3:0] s_idx = 4'h0;
  logic [23:0] s_dat = 24'h00_0000;
  logic tick, sck, sd, sel;
  logic pol = 0;
  logic [23:0] mem [16];
  logic [31:0] seed = 32'ha0a7_cf38;
  int err_total = 0;
  int n_checks = 0;
  // Set 00/01/10/11 across rates, sizes, gaps and polarities
  logic [7:0] cfgs [6] = '{8'h00, 8'h2a, 8'h11, 8'h1c, 8'h36, 8'h0c};
  always #10 clock = ~clock;
  wcp_capture_port #(.SAMPLE_CYCLES(SC)) dut (.clock(clock), .rst_b(rst_b), .host_link_i2c(i2c),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata_q(rdat), .sample_wr(s_wr),
    .sample_idx(s_idx), .sample_data(s_dat), .sample_tick_q(tick), .serial_clock_out_q(sck),
    .serial_data_out_q(sd), .select_out_q(sel));
  wcp_rx_model rx (.sck(sck), .sd(sd), .sel(sel), .pol(pol));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task end_of_test();
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wd <= d;
    wr_s <= 1;
    @(posedge clock);
    wr_s <= 0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd_s <= 1;
    @(posedge clock);
    rd_s <= 0;
    @(negedge clock);
    v = rdat;
  endtask
  task wait_tick();
    int i;
    for (i = 0; i < SC + 8; i++) begin
      @(negedge clock);
      if (tick === 1'b1) break;
    end
    if (i == SC + 8) begin
      err_total++;
      end_of_test();
    end
  endtask
  task wait_idle();
    logic [7:0] v;
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(`WCP_REG_STATUS, v);
      if (v[0] === 1'b0) break;
    end
    if (i == 3000) begin
      err_total++;
      end_of_test();
    end
  endtask
  initial begin
    logic [7:0] v;
    logic [31:0] t;
    logic [7:0] st;
    int c, j, nw, first, h, pk, len, ntr;
    repeat (5) @(posedge clock);
    rst_b <= 1;
    repeat (4) @(posedge clock);
    rd(`WCP_REG_GEN_CFG, v);
    chk("gen_cfg", v, `WCP_GEN_RST);
    rd(`WCP_REG_PORT_CFG, v);
    chk("port_cfg", v, `WCP_CFG_RST);
    wr(`WCP_REG_PORT_CFG, 8'hff);
    rd(`WCP_REG_PORT_CFG, v);
    chk("port_cfg_top", v, `WCP_CFG_STORE_MASK);
    rd(4'h7, v);
    chk("unmapped", v, 8'h00);
    for (j = 0; j < 16; j++) begin
      t = rnd();
      mem[j] = t[23:0];
      @(posedge clock);
      s_wr <= 1;
      s_idx <= j[3:0];
      s_dat <= t[23:0];
    end
    @(posedge clock);
    s_wr <= 0;
    // Enable bit alone must not start the port in the other host mode
    wr(`WCP_REG_PORT_CFG, 8'h00);
    pol = 0;
    wr(`WCP_REG_GEN_CFG, 8'h40);
    wait_tick();
    wait_tick();
    chk("no_i2c", rx.q.size(), 0);
    wr(`WCP_REG_GEN_CFG, 8'h00);
    i2c <= 1;
    for (c = 0; c < 6; c++) begin
      t = rnd();
      v = cfgs[c] | (t[7:0] & 8'hc0);
      wr(`WCP_REG_PORT_CFG, v);
      pol = v[5];
      rx.q.delete();
      rx.acts = 0;
      rx.bits = 0;
      wr(`WCP_REG_GEN_CFG, 8'h40);
      repeat (3) wait_tick();
      wait_idle();
      wr(`WCP_REG_GEN_CFG, 8'h00);
      first = (v[4:3] == `WCP_SET_POWER) ? 7 : 0;
      nw = (v[4:3] == `WCP_SET_WAVE) ? 7 : (v[4:3] == `WCP_SET_POWER) ? 9 : 16;
      h = v[0] ? 6 : 3;
      pk = v[2] ? (v[1] ? nw * 4 : nw) : 1;
      len = nw * 64 * h + (v[2] ? (pk - 1) * 14 * h : 0);
      ntr = (len < SC) ? 3 : 2;
      chk("words", rx.q.size(), nw * ntr);
      chk("packages", rx.acts, pk * ntr);
      rd(`WCP_REG_STATUS, st);
      chk("status", st, {5'h00, ntr == 2, 2'b10});
      for (j = 0; j < rx.q.size(); j++) begin
        chk("word", rx.q[j], {{8{mem[first + j % nw][23]}}, mem[first + j % nw]});
      end
    end
    end_of_test();
  end
endmodule // waveform_capture_serial_master_bench
